// file: verilog/sras_slave.sv
// Register slave end: clocked by the link clock, registers on the device clock.
`default_nettype none
module sras_slave #(
	parameter logic [31:0] FW_REV = sras_pkg::FW_REV_RESET
) (
	input  wire logic  CLK,
	input  wire logic  RST_N,
	sras_if.slave      LINK,
	output logic [7:0] REG_ADDR,
	output logic [31:0] REG_WDATA,
	output logic       REG_WTOGGLE,
	output logic       CMD_ZERO_GYRO_TOGGLE,
	output logic [7:0] RD_ADDR,
	input  wire logic [31:0] RD_DATA
);
	// ----------------------------------------
	// Link domain. Select high resets the counts, shifter and output, not the toggles.
	// ----------------------------------------
	logic [2:0]  bit_q;
	logic [2:0]  byte_q;
	logic [7:0]  sh_q;
	logic        wr_q;
	logic [31:0] tx_q;
	logic [7:0]  addr_q;
	logic [31:0] wd_q;
	logic        wt_q;
	logic        zt_q;
	logic        at_q;
	logic [7:0]  rx;
	logic        miso_q;
	assign rx = {sh_q[6:0], LINK.mosi};
	always_ff @(posedge LINK.sck or posedge LINK.ss_n) begin
		if (LINK.ss_n) begin // [R1] [R15]
			bit_q  <= 3'h0;
			byte_q <= 3'h0;
			sh_q   <= 8'h00;
			wr_q   <= 1'b0;
		end else begin // [R2]
			bit_q <= bit_q + 3'h1;
			sh_q  <= rx;
			if (bit_q == 3'h7) begin
				if (byte_q == 3'h0)
					wr_q <= (rx == sras_pkg::OP_WRITE); // [R4]
				if (byte_q == 3'h5)
					byte_q <= wr_q ? 3'h6 : 3'h2; // [R7] [R10]
				else if (byte_q != 3'h6)
					byte_q <= byte_q + 3'h1;
			end
		end
	end
	always_ff @(posedge LINK.sck) begin
		if (!LINK.ss_n && bit_q == 3'h7) begin
			if (byte_q == 3'h1 || (byte_q == 3'h5 && !wr_q))
				addr_q <= rx; // [R4] [R7]
			if (wr_q && byte_q >= 3'h2 && byte_q <= 3'h5)
				wd_q <= {wd_q[23:0], rx}; // [R8]
		end
	end
	// Toggles must survive deselect, so only the device reset clears them.
	always_ff @(posedge LINK.sck or negedge RST_N) begin
		if (!RST_N) begin
			wt_q <= 1'b0;
			zt_q <= 1'b0;
			at_q <= 1'b0;
		end else if (!LINK.ss_n && bit_q == 3'h7) begin
			if (byte_q == 3'h1 || (byte_q == 3'h5 && !wr_q))
				at_q <= ~at_q; // [R7]
			if (wr_q && byte_q == 3'h5) begin
				if (addr_q == sras_pkg::ADDR_ZERO_GYRO)
					zt_q <= ~zt_q; // [R11] [R13]
				else if (addr_q != sras_pkg::ADDR_FW_REV)
					wt_q <= ~wt_q;
			end
		end
	end
	// Output bit changes on falling edges, loaded on the falling edge after each address byte.
	always_ff @(negedge LINK.sck or posedge LINK.ss_n) begin
		if (LINK.ss_n) begin
			tx_q   <= 32'h0;
			miso_q <= 1'b0;
		end else if (bit_q == 3'h0) begin
			if (byte_q == 3'h2)
				tx_q <= (addr_q == sras_pkg::ADDR_FW_REV) ? FW_REV // [R12] [R14]
					: (wr_q ? 32'h0 : RD_DATA); // [R5] [R9]
			else
				tx_q <= {tx_q[30:0], 1'b0};
			miso_q <= (byte_q == 3'h2) ? ((addr_q == sras_pkg::ADDR_FW_REV) ? FW_REV[31]
				: (wr_q ? 1'b0 : RD_DATA[31])) : tx_q[30];
		end else begin
			tx_q   <= {tx_q[30:0], 1'b0};
			miso_q <= tx_q[30];
		end
	end
	assign LINK.miso = miso_q;
	// ----------------------------------------
	// Device domain. RD_DATA must be ready by the falling edge that ends the address byte.
	// ----------------------------------------
	logic [2:0] wt_s;
	logic [2:0] zt_s;
	logic [2:0] at_s;
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			wt_s                 <= 3'h0;
			zt_s                 <= 3'h0;
			at_s                 <= 3'h0;
			REG_WTOGGLE          <= 1'b0;
			CMD_ZERO_GYRO_TOGGLE <= 1'b0;
			REG_ADDR             <= 8'h00;
			REG_WDATA            <= 32'h0;
			RD_ADDR              <= 8'h00;
		end else begin
			wt_s <= {wt_s[1:0], wt_q};
			zt_s <= {zt_s[1:0], zt_q};
			at_s <= {at_s[1:0], at_q};
			REG_WTOGGLE          <= wt_s[1] ^ wt_s[2];
			CMD_ZERO_GYRO_TOGGLE <= zt_s[1] ^ zt_s[2];
			// The address word is taken only after its toggle is synchronised.
			if (at_s[1] ^ at_s[2])
				RD_ADDR <= addr_q; // [R5]
			if (wt_s[1] ^ wt_s[2]) begin
				REG_ADDR  <= addr_q;
				REG_WDATA <= wd_q;
			end
		end
	end
endmodule : sras_slave
`default_nettype wire

// file: verilog/sras_pkg.sv
// Package of constants shared by both ends of the register access link.
// Overview of operation
// [R1] Device stays idle until selected and clocked.
// [R2] Mode 0: sample rising, change falling.
// [R3] Master waits 5 us between bytes.
// [R4] Opcode byte then register address byte.
// [R5] Read returns four bytes, MSB first.
// [R6] Master holds data line low during read.
// [R7] Next address on last byte chains reads.
// [R8] Write captures four bytes, MSB first.
// [R9] Device drives output low during write data.
// [R10] One register per write operation.
// [R11] Command is write of four zero bytes; the slave acts on any write to 0xAC and does not check the data.
// [R12] Only revision query returns data.
// [R13] Gyro zero command address is 0xAC.
// [R14] Revision query address is 0xAA.
// [R15] Deselect abandons operation, resets byte count.
`default_nettype none
package sras_pkg;
	localparam logic [7:0] OP_READ       = 8'h00;
	localparam logic [7:0] OP_WRITE      = 8'h01;
	localparam logic [7:0] ADDR_ZERO_GYRO = 8'hAC;
	localparam logic [7:0] ADDR_FW_REV   = 8'hAA;
	localparam int         DATA_BYTES    = 4;
	localparam int         CLK_MHZ       = 50;
	localparam int         BYTE_GAP_NS   = 5000;
	localparam int         BYTE_GAP_CYC  = (BYTE_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int         SCK_HALF_CYC  = 5;
	localparam logic [31:0] FW_REV_RESET = 32'h0000_0001;
endpackage : sras_pkg
`default_nettype wire

// file: verilog/sras_if.sv
// Interface joining the master end and the register slave end.
`default_nettype none
interface sras_if;
	logic sck;
	logic ss_n;
	logic mosi;
	logic miso;
	modport slave  (input sck, input ss_n, input mosi, output miso);
	modport master (output sck, output ss_n, output mosi, input miso);
endinterface : sras_if
`default_nettype wire

// file: verilog/sras_master.sv
// Master end: makes the link clock by dividing its own clock.
`default_nettype none
module sras_master (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	sras_if.master           LINK,
	input  wire logic        START,
	input  wire logic        WRITE,
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	output logic             BUSY,
	output logic             DONE,
	output logic [31:0]      RDATA
);
	typedef enum {IDLE, SHIFT, GAP, END} sras_st_t;
	sras_st_t    st_q;
	logic [47:0] out_q;
	logic [31:0] in_q;
	logic [2:0]  bit_q;
	logic [2:0]  byte_q;
	logic [15:0] cnt_q;
	logic        sck_q;
	logic [1:0]  miso_s;
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			st_q <= IDLE; sck_q <= 1'b0; BUSY <= 1'b0; DONE <= 1'b0;
			out_q <= 48'h0; in_q <= 32'h0; bit_q <= 3'h0; byte_q <= 3'h0;
			cnt_q <= 16'h0; RDATA <= 32'h0; miso_s <= 2'h0;
		end else begin
			miso_s <= {miso_s[0], LINK.miso};
			DONE   <= 1'b0;
			case (st_q)
				IDLE: if (START) begin // [R4] [R10] [R11]
					out_q <= {(WRITE ? sras_pkg::OP_WRITE : sras_pkg::OP_READ), ADDR,
						(WRITE ? WDATA : 32'h0)}; // [R6]
					BUSY <= 1'b1; byte_q <= 3'h0; bit_q <= 3'h0;
					cnt_q <= 16'(sras_pkg::BYTE_GAP_CYC); st_q <= GAP;
				end
				SHIFT: begin // [R2]
					if (cnt_q != 16'h0) cnt_q <= cnt_q - 16'h1;
					else begin
						cnt_q <= 16'(sras_pkg::SCK_HALF_CYC);
						sck_q <= ~sck_q;
						if (sck_q) begin
							out_q <= {out_q[46:0], 1'b0};
							bit_q <= bit_q + 3'h1;
							if (bit_q == 3'h7) begin
								byte_q <= byte_q + 3'h1;
								cnt_q  <= 16'(sras_pkg::BYTE_GAP_CYC); // [R3]
								st_q   <= (byte_q == 3'h5) ? END : GAP;
							end
						end else if (byte_q >= 3'h2)
							in_q <= {in_q[30:0], miso_s[1]};
					end
				end
				GAP: if (cnt_q != 16'h0) cnt_q <= cnt_q - 16'h1;
					else begin cnt_q <= 16'(sras_pkg::SCK_HALF_CYC); st_q <= SHIFT; end
				END: if (cnt_q != 16'h0) cnt_q <= cnt_q - 16'h1;
					else begin RDATA <= in_q; DONE <= 1'b1; BUSY <= 1'b0; st_q <= IDLE; end
				default: st_q <= IDLE;
			endcase
		end
	end
	assign LINK.sck  = sck_q;
	assign LINK.ss_n = ~BUSY;
	assign LINK.mosi = out_q[47];
endmodule : sras_master
`default_nettype wire

// file: verif/sras_asserts.sv
// Checker of the link signals between the two ends.
`default_nettype none
module sras_asserts #(parameter logic [31:0] FW_REV = 32'h0) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        sk_q;
	logic [6:0]  bc_q;
	logic [15:0] sr_q;
	wire logic   rise = sck && !sk_q;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	always_ff @(posedge CLK) sk_q <= sck;
	// Counts follow deselect, so a dropped frame never shifts later checks.
	always_ff @(posedge CLK) begin
		if (ss_n) bc_q <= 7'h00;
		else if (rise) bc_q <= bc_q + 7'h01;
	end
	always_ff @(posedge CLK) begin
		if (ss_n) sr_q <= 16'h0000;
		else if (rise && bc_q < 7'h10) sr_q <= {sr_q[14:0], mosi};
	end
	chk_sck_idle: assert property (ss_n |-> !sck) else $error("sck high");
	chk_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("mosi moved");
	chk_miso_hold: assert property (!ss_n && sck && $past(sck) |-> $stable(miso))
		else $error("miso moved");
	chk_op_legal: assert property (rise && bc_q == 7'h08 |-> sr_q[7:1] == 7'h00)
		else $error("bad opcode");
	chk_wr_miso_low: assert property (rise && bc_q > 7'h0F && sr_q[15:8] == 8'h01
		&& sr_q[7:0] != 8'hAA |-> !miso) else $error("miso not low");
	chk_rd_mosi_low: assert property (rise && bc_q > 7'h0F && bc_q < 7'h28
		&& sr_q[15:8] == 8'h00 |-> !mosi) else $error("mosi not low");
	chk_wr_single: assert property (rise && sr_q[15:8] == 8'h01 |-> bc_q < 7'h30)
		else $error("write too long");
	chk_rev_out: assert property (rise && bc_q > 7'h0F && bc_q < 7'h30
		&& sr_q == 16'h01AA |-> miso == FW_REV[7'h2F - bc_q]) else $error("bad revision");
	cover property (rise && bc_q == 7'h2F && sr_q[15:8] == 8'h00);
	cover property (rise && bc_q == 7'h2F && sr_q == 16'h01AC);
	cover property (rise && bc_q == 7'h2F && sr_q == 16'h01AA);
endmodule : sras_asserts
`default_nettype wire

// file: verif/testbench.sv
// Bench joining the master end and the slave end.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] REV = 32'hC0DE_0001; // Arbitrary value.
	logic        clk;
	logic        rst_n;
	logic        start;
	logic        wr;
	logic        busy;
	logic        done;
	logic [7:0]  addr;
	logic [7:0]  ra;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [39:0] wseen;
	logic [39:0] wcur;
	logic        wtog;
	logic        zg;
	int          wn;
	int          zn;
	int          num_errors;
	int          checks_done;
	sras_if lnk ();
	sras_master u_sras_master (.CLK(clk), .RST_N(rst_n), .LINK(lnk), .START(start), .WRITE(wr),
		.ADDR(addr), .WDATA(wdata), .BUSY(busy), .DONE(done), .RDATA(rdata));
	sras_slave #(.FW_REV(REV)) u_sras_slave (.CLK(clk), .RST_N(rst_n), .LINK(lnk),
		.REG_ADDR(wcur[39:32]), .REG_WDATA(wcur[31:0]), .REG_WTOGGLE(wtog),
		.CMD_ZERO_GYRO_TOGGLE(zg), .RD_ADDR(ra), .RD_DATA({ra, ~ra, 8'h5A, ra}));
	sras_asserts #(.FW_REV(REV)) u_chk (.CLK(clk), .RST_N(rst_n), .sck(lnk.sck),
		.ss_n(lnk.ss_n), .mosi(lnk.mosi), .miso(lnk.miso));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rst_n !== 1'b1) begin
			wn <= 0;
			zn <= 0;
		end else begin
			wn <= wn + int'(wtog === 1'b1);
			zn <= zn + int'(zg === 1'b1);
		end
		if (wtog === 1'b1) wseen <= wcur;
	end
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		for (n = 0; n < 9 && busy !== 1'b0; n++) @(negedge clk);
		@(negedge clk);
		{start, wr, addr, wdata} = {1'b1, w, a, d};
		@(negedge clk);
		start = 1'b0;
		for (n = 0; n < 4000 && done !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 4000) begin
			num_errors++;
			stop_test();
		end
		$display("op %h done", a);
	endtask : op
	initial begin
		{rst_n, start, wr, addr, wdata, num_errors, checks_done} = '0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		op(1'b1, 8'h12, 32'hA5C3_0F96);
		chk(wseen, 40'h12_A5C3_0F96);
		op(1'b1, 8'h7F, 32'hFFFF_FFFF);
		chk(wseen, 40'h7F_FFFF_FFFF);
		op(1'b0, 8'h3C, 32'h0);
		chk(40'(rdata), 40'h3CC3_5A3C);
		chk(40'(wn), 40'h2);
		op(1'b1, 8'hAC, 32'h0);
		chk(40'(zn), 40'h1);
		op(1'b1, 8'hAA, 32'h0);
		chk(40'(rdata), 40'(REV));
		chk(40'(zn), 40'h1);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
